// ==== core/mos_output_select.sv ====
// Purpose: multi-function output selection for two relays and two transistor outputs
// Assumes: condition inputs come from logic on the same clock
// Notes: registers over Avalon-MM, one wait state per access
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module mos_output_select #(
    parameter int unsigned PULSE_CYCLES = mos_pkg::PULSE_CYCLES
) (
    input wire logic ref_clk_in, // system clock
    input wire logic srst_in, // sync reset, active high
    input wire logic [5:0] avs_address_in, // byte address
    input wire logic avs_read_in, // read request
    input wire logic avs_write_in, // write request
    input wire logic [31:0] avs_writedata_in, // write data
    input wire logic [3:0] avs_byteenable_in, // byte lanes
    output logic [31:0] avs_readdata_out, // read data
    output logic avs_waitrequest_out, // stall
    input wire mos_pkg::mos_cond_type cond_in, // drive conditions
    input wire mos_pkg::mos_meas_type meas_in, // drive measurements
    output logic relay_one_out, // relay 1 contact
    output logic relay_two_out, // relay 2 contact
    output logic transistor_output_a_out, // first transistor output
    output logic transistor_output_b_out, // second transistor output
    output logic irq_out // level interrupt
);
    import mos_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave
    logic ack;
    logic [7:0][31:0] cfg;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [N_OUT-1:0] out_reg;
    logic [N_OUT-1:0] cond_now;

    wire req = avs_read_in | avs_write_in;
    wire wr_fire = avs_write_in & ack;
    wire aligned = avs_address_in[1:0] == 2'b00;
    wire cfg_hit = aligned && avs_address_in < ADDR_IRQ_STATUS;
    wire hit_status = avs_address_in == ADDR_IRQ_STATUS;
    wire hit_mask = avs_address_in == ADDR_IRQ_MASK;
    wire hit_state = avs_address_in == ADDR_STATE;
    wire [2:0] cfg_idx = avs_address_in[4:2];
    wire [31:0] wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
        {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    wire [31:0] wbits = avs_writedata_in & wmask;
    wire [31:0] next_cfg_word = ((cfg[cfg_idx] & ~wmask) | wbits) & CFG_MASK[cfg_idx];
    wire [31:0] rd_mux = cfg_hit ? cfg[cfg_idx] :
        hit_status ? {28'h000_0000, irq_status} :
        hit_mask ? {28'h000_0000, irq_mask} :
        hit_state ? {24'h00_0000, cond_now, out_reg} : 32'h0000_0000;

    // one wait state keeps read data coming from a flop
    assign avs_waitrequest_out = req & ~ack;

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            ack <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end
        else
        begin
            ack <= req & ~ack;
            if (avs_read_in && !ack)
            begin
                avs_readdata_out <= rd_mux;
            end
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            cfg <= CFG_RST;
            irq_mask <= '0;
        end
        else if (wr_fire)
        begin
            if (cfg_hit)
            begin
                cfg[cfg_idx] <= next_cfg_word;
            end
            if (hit_mask)
            begin
                irq_mask <= wbits[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings
    wire [N_OUT-1:0] pol = cfg[CFG_POL][N_OUT-1:0];
    wire [DW-1:0] target = cfg[CFG_TARGET][DW-1:0];
    wire [DW-1:0] prewarn = cfg[CFG_PREWARN][DW-1:0];
    wire [DW-1:0] heat_thr = cfg[CFG_OVERHEAT][DW-1:0];
    wire [DW-1:0] brake_lvl = cfg[CFG_BRAKE][DW-1:0];
    wire [DW-1:0] torque_lvl = cfg[CFG_TORQUE][DW-1:0];
    wire [DW-1:0] gain = cfg[CFG_GAIN][DW-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // timed pulses for step and cycle completion
    logic step_pulse;
    logic cycle_pulse;

    mos_pulse_stretch #(.CYCLES(PULSE_CYCLES)) u_step (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .trig_in(cond_in.seq_step_done),
        .pulse_out(step_pulse)
    );

    mos_pulse_stretch #(.CYCLES(PULSE_CYCLES)) u_cycle (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .trig_in(cond_in.seq_cycle_done),
        .pulse_out(cycle_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // frequency pulse train: gain is 8.8 fixed point, toggles on accumulator carry
    logic [DW-1:0] acc;
    logic freq_pulse;
    wire [2*DW-1:0] prod = meas_in.out_freq * gain;
    wire [DW:0] next_acc = {1'b0, acc} + {1'b0, prod[DW+7:8]};

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            acc <= '0;
            freq_pulse <= 1'b0;
        end
        else
        begin
            acc <= next_acc[DW-1:0];
            freq_pulse <= freq_pulse ^ next_acc[DW];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // condition table indexed by selection code; codes 0-10, 30, 31 stay open
    logic [63:0] cond_vec;
    wire [15:0] seq_onehot = 16'h0001 << cond_in.seq_step;
    wire [15:0] speed_onehot = 16'h0001 << cond_in.speed_step;

    always_comb
    begin
        cond_vec = 64'h0000_0000_0000_0000;
        cond_vec[SEL_FAULT] = cond_in.fault;
        cond_vec[SEL_BLOCK] = cond_in.base_block;
        cond_vec[SEL_ZERO_ANY] = ~cond_in.volt_out;
        cond_vec[SEL_ZERO_RUN] = ~cond_in.volt_out & cond_in.run_cmd;
        cond_vec[SEL_TARGET] = meas_in.counter >= target;
        cond_vec[SEL_PREWARN] = meas_in.counter >= prewarn;
        cond_vec[SEL_SEQ_RUN] = cond_in.seq_run;
        cond_vec[SEL_SEQ_PAUSE] = cond_in.seq_pause;
        cond_vec[SEL_STEP_DONE] = step_pulse;
        cond_vec[SEL_CYCLE_DONE] = cycle_pulse;
        cond_vec[SEL_OVERHEAT] = meas_in.heatsink > heat_thr;
        cond_vec[SEL_BACKLASH] = cond_in.backlash_dwell;
        cond_vec[SEL_EXT_SRC] = cond_in.ext_source;
        cond_vec[SEL_OVERTORQUE] = meas_in.current > torque_lvl;
        cond_vec[SEL_FREQ_PULSE] = freq_pulse;
        cond_vec[SEL_BRAKE] = meas_in.dc_bus > brake_lvl;
        cond_vec[SEL_AUX_BASE +: 3] = cond_in.aux_motor;
        // sequencer step only counts while the program runs
        cond_vec[SEL_SEQ_STEP_BASE +: 16] = cond_in.seq_run ? seq_onehot : 16'h0000;
        cond_vec[SEL_SPEED_STEP_BASE +: 16] = speed_onehot;
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-output selection and polarity
    logic [N_OUT-1:0] next_out;

    for (genvar gi = 0; gi < N_OUT; gi++)
    begin : g_out
        wire [SEL_W-1:0] code = cfg[CFG_SEL][gi*SEL_SPACING +: SEL_W];
        wire bad_freq = code == SEL_FREQ_PULSE && gi != OUT_FREQ_IDX;
        wire bad_brake = code == SEL_BRAKE && gi != OUT_BRAKE_IDX;
        assign cond_now[gi] = cond_vec[code] & ~bad_freq & ~bad_brake;
        assign next_out[gi] = cond_now[gi] ^ pol[gi];
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            out_reg <= '0;
        end
        else
        begin
            out_reg <= next_out;
        end
    end

    assign relay_one_out = out_reg[0];
    assign relay_two_out = out_reg[1];
    assign transistor_output_a_out = out_reg[2];
    assign transistor_output_b_out = out_reg[3];

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: set wins over write-one-to-clear
    logic fault_d;
    logic torque_d;
    wire torque_now = cond_vec[SEL_OVERTORQUE];
    wire [IRQ_W-1:0] irq_set = {torque_now & ~torque_d, cond_in.seq_cycle_done,
        cond_in.seq_step_done, cond_in.fault & ~fault_d};
    wire [IRQ_W-1:0] irq_clr = (wr_fire && hit_status) ? wbits[IRQ_W-1:0] : '0;

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            fault_d <= 1'b0;
            torque_d <= 1'b0;
            irq_status <= '0;
        end
        else
        begin
            fault_d <= cond_in.fault;
            torque_d <= torque_now;
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    assign irq_out = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    wire [SEL_W-1:0] code0 = cfg[CFG_SEL][SEL_W-1:0];
    wire [SEL_W-1:0] code2 = cfg[CFG_SEL][2*SEL_SPACING +: SEL_W];

    reset_open_a: assert property (disable iff (1'b0) srst_in |=> out_reg == '0)
        else $error("outputs not open after reset");
    fault_close_a: assert property (code0 == SEL_FAULT && !pol[0] && cond_in.fault
        |=> relay_one_out)
        else $error("fault did not close relay one");
    block_close_a: assert property (code0 == SEL_BLOCK |=>
        relay_one_out == ($past(cond_in.base_block) ^ $past(pol[0])))
        else $error("block indication wrong");
    zero_run_a: assert property (code0 == SEL_ZERO_RUN && !pol[0] && !cond_in.run_cmd
        |=> !relay_one_out)
        else $error("zero speed closed without run command");
    zero_close_a: assert property (code0 == SEL_ZERO_RUN && !pol[0]
        && !cond_in.volt_out && cond_in.run_cmd |=> relay_one_out)
        else $error("zero speed in run not shown");
    target_cnt_a: assert property (code0 == SEL_TARGET |=>
        relay_one_out == (($past(meas_in.counter) >= $past(target)) ^ $past(pol[0])))
        else $error("target count output wrong");
    prewarn_cnt_a: assert property (code0 == SEL_PREWARN |=>
        relay_one_out == (($past(meas_in.counter) >= $past(prewarn)) ^ $past(pol[0])))
        else $error("prewarn output wrong");
    seq_run_a: assert property (code0 == SEL_SEQ_RUN && pol[0] == 1'b0
        && cond_in.seq_run |=> relay_one_out)
        else $error("sequencer running not shown");
    pause_close_a: assert property (code0 == SEL_SEQ_PAUSE |=>
        relay_one_out == ($past(cond_in.seq_pause) ^ $past(pol[0])))
        else $error("pause output wrong");
    step_pulse_a: assert property (code0 == SEL_STEP_DONE && !pol[0]
        && cond_in.seq_step_done ##1 code0 == SEL_STEP_DONE && !pol[0] |=> relay_one_out)
        else $error("step pulse missing");
    cycle_pulse_a: assert property (code0 == SEL_CYCLE_DONE && !pol[0]
        && cond_in.seq_cycle_done ##1 code0 == SEL_CYCLE_DONE && !pol[0] |=> relay_one_out)
        else $error("cycle pulse missing");
    heat_close_a: assert property (code0 == SEL_OVERHEAT |=>
        relay_one_out == (($past(meas_in.heatsink) > $past(heat_thr)) ^ $past(pol[0])))
        else $error("over-heat output wrong");
    backlash_a: assert property (code0 == SEL_BACKLASH |=>
        relay_one_out == ($past(cond_in.backlash_dwell) ^ $past(pol[0])))
        else $error("backlash indication wrong");
    ext_src_a: assert property (code0 == SEL_EXT_SRC |=>
        relay_one_out == ($past(cond_in.ext_source) ^ $past(pol[0])))
        else $error("source indication wrong");
    torque_close_a: assert property (code0 == SEL_OVERTORQUE |=>
        relay_one_out == (($past(meas_in.current) > $past(torque_lvl)) ^ $past(pol[0])))
        else $error("over-torque output wrong");
    freq_only_four_a: assert property (code0 == SEL_FREQ_PULSE |=>
        relay_one_out == $past(pol[0]))
        else $error("pulse train leaked to relay one");
    brake_only_a: assert property (code2 == SEL_BRAKE |=>
        transistor_output_a_out == (($past(meas_in.dc_bus) > $past(brake_lvl))
        ^ $past(pol[2])))
        else $error("braking output wrong");
    brake_refuse_a: assert property (code0 == SEL_BRAKE |=>
        relay_one_out == $past(pol[0]))
        else $error("braking leaked to relay one");
    aux_one_a: assert property (code0 == SEL_AUX_BASE |=>
        relay_one_out == ($past(cond_in.aux_motor[0]) ^ $past(pol[0])))
        else $error("auxiliary motor output wrong");
    speed_step_a: assert property (code0 == SEL_SPEED_STEP_BASE + 6'h05 && !pol[0]
        |=> relay_one_out == ($past(cond_in.speed_step) == 4'h5))
        else $error("speed step indication wrong");
    seq_step_a: assert property (code0[5:4] == 2'b10 && !pol[0] |=> relay_one_out ==
        ($past(cond_in.seq_run) && $past(cond_in.seq_step) == $past(code0[3:0])))
        else $error("sequencer step indication wrong");
    polarity_a: assert property (code0 == SEL_FAULT && pol[0] && cond_in.fault
        |=> !relay_one_out)
        else $error("polarity not applied");
    // a step event in the same cycle as its clear must still latch
    irq_set_a: assert property (cond_in.seq_step_done |=> irq_status[IRQ_STEP])
        else $error("step event not latched");
    bus_wait_a: assert property (req && !ack |=> ack)
        else $error("bus answer not one cycle later");

    // helper: cycles that the stretched step pulse has stood since its trigger
    logic [31:0] step_run;
    wire [31:0] next_step_run = (step_pulse && !cond_in.seq_step_done) ?
        step_run + 32'h0000_0001 : 32'h0000_0000;

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            step_run <= 32'h0000_0000;
        end
        else
        begin
            step_run <= next_step_run;
        end
    end

    step_len_a: assert property (step_run <= PULSE_CYCLES)
        else $error("step pulse stood too long");

    fault_cover_c: cover property (code0 == SEL_FAULT && cond_in.fault ##1 relay_one_out);
    step_cover_c: cover property (cond_in.seq_step_done ##2 out_reg != '0);
    irq_cover_c: cover property (irq_out ##1 wr_fire && hit_status);
endmodule : mos_output_select

// ==== core/mos_pkg.sv ====
// Purpose: constants, codes and carriers for the output selector
// Assumes: 20 MHz reference clock, 32-bit register bus
// Notes: one select field of 6 bits per output, spaced one byte apart
package mos_pkg;
    localparam int N_OUT = 4;
    localparam int DW = 16;
    localparam int CLK_HZ = 20_000_000;
    localparam int PULSE_MS = 500;
    localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;

    // selection codes
    localparam logic [5:0] SEL_FAULT = 6'h0B;
    localparam logic [5:0] SEL_BLOCK = 6'h0C;
    localparam logic [5:0] SEL_ZERO_ANY = 6'h0D;
    localparam logic [5:0] SEL_ZERO_RUN = 6'h0E;
    localparam logic [5:0] SEL_TARGET = 6'h0F;
    localparam logic [5:0] SEL_PREWARN = 6'h10;
    localparam logic [5:0] SEL_SEQ_RUN = 6'h11;
    localparam logic [5:0] SEL_SEQ_PAUSE = 6'h12;
    localparam logic [5:0] SEL_STEP_DONE = 6'h13;
    localparam logic [5:0] SEL_CYCLE_DONE = 6'h14;
    localparam logic [5:0] SEL_OVERHEAT = 6'h15;
    localparam logic [5:0] SEL_BACKLASH = 6'h16;
    localparam logic [5:0] SEL_EXT_SRC = 6'h17;
    localparam logic [5:0] SEL_OVERTORQUE = 6'h18;
    localparam logic [5:0] SEL_FREQ_PULSE = 6'h19;
    localparam logic [5:0] SEL_BRAKE = 6'h1A;
    localparam logic [5:0] SEL_AUX_BASE = 6'h1B;
    localparam logic [5:0] SEL_SEQ_STEP_BASE = 6'h20;
    localparam logic [5:0] SEL_SPEED_STEP_BASE = 6'h30;
    localparam int OUT_BRAKE_IDX = 2;
    localparam int OUT_FREQ_IDX = 3;
    localparam int SEL_W = 6;
    localparam int SEL_SPACING = 8;

    // byte addresses
    localparam logic [5:0] ADDR_SEL = 6'h00;
    localparam logic [5:0] ADDR_POL = 6'h04;
    localparam logic [5:0] ADDR_TARGET = 6'h08;
    localparam logic [5:0] ADDR_PREWARN = 6'h0C;
    localparam logic [5:0] ADDR_OVERHEAT = 6'h10;
    localparam logic [5:0] ADDR_BRAKE = 6'h14;
    localparam logic [5:0] ADDR_TORQUE = 6'h18;
    localparam logic [5:0] ADDR_GAIN = 6'h1C;
    localparam logic [5:0] ADDR_IRQ_STATUS = 6'h20;
    localparam logic [5:0] ADDR_IRQ_MASK = 6'h24;
    localparam logic [5:0] ADDR_STATE = 6'h28;

    // config word index = byte address / 4
    localparam int CFG_SEL = 0;
    localparam int CFG_POL = 1;
    localparam int CFG_TARGET = 2;
    localparam int CFG_PREWARN = 3;
    localparam int CFG_OVERHEAT = 4;
    localparam int CFG_BRAKE = 5;
    localparam int CFG_TORQUE = 6;
    localparam int CFG_GAIN = 7;
    localparam logic [7:0][31:0] CFG_RST = {
        32'h0000_0100, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
        32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_0000, 32'h0905_010B};
    localparam logic [7:0][31:0] CFG_MASK = {
        32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
        32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_000F, 32'h3F3F_3F3F};

    localparam int IRQ_W = 4;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_STEP = 1;
    localparam int IRQ_CYCLE = 2;
    localparam int IRQ_TORQUE = 3;

    typedef struct packed {
        logic fault;
        logic base_block;
        logic volt_out;
        logic run_cmd;
        logic seq_run;
        logic seq_pause;
        logic seq_step_done;
        logic seq_cycle_done;
        logic backlash_dwell;
        logic ext_source;
        logic [2:0] aux_motor;
        logic [3:0] seq_step;
        logic [3:0] speed_step;
    } mos_cond_type;

    typedef struct packed {
        logic [DW-1:0] counter;
        logic [DW-1:0] heatsink;
        logic [DW-1:0] current;
        logic [DW-1:0] dc_bus;
        logic [DW-1:0] out_freq;
    } mos_meas_type;
endpackage : mos_pkg

// ==== core/mos_pulse_stretch.sv ====
// Purpose: stretch a one-cycle event into a fixed-length pulse
// Assumes: trigger is a one-cycle pulse from same-clock logic
// Notes: a new trigger restarts the full length
`timescale 1ns/1ps
module mos_pulse_stretch #(
    parameter int unsigned CYCLES = mos_pkg::PULSE_CYCLES
) (
    input wire logic ref_clk_in, // system clock
    input wire logic srst_in, // sync reset
    input wire logic trig_in, // event pulse
    output logic pulse_out // stretched pulse
);
    import mos_pkg::*;
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt;
    wire [CW-1:0] next_cnt = trig_in ? CW'(CYCLES) :
        (cnt != '0) ? cnt - CW'(1) : cnt;

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            cnt <= '0;
            pulse_out <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            pulse_out <= next_cnt != '0;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    pulse_start_a: assert property (trig_in |=> pulse_out && cnt == CW'(CYCLES))
        else $error("pulse did not start after event");
    pulse_end_a: assert property (pulse_out && cnt == CW'(1) && !trig_in |=> !pulse_out)
        else $error("pulse length wrong");
    pulse_cover_c: cover property (trig_in ##1 pulse_out);
endmodule : mos_pulse_stretch

// ==== dv/mos_load.sv ====
// Purpose: external load wired to the four output contacts
// Assumes: contacts are plain levels, closed = 1
// Notes: counts rising edges on the second transistor output for pulse-train checks
`timescale 1ns/1ps
module mos_load (
    input wire logic ref_clk_in, // system clock
    input wire logic clr_in, // clears the edge count
    input wire logic [3:0] contact_in, // relay one at bit 0
    output logic [3:0] sensed_out, // contacts as the load sees them
    output logic [7:0] b_edges_out // rising edges on output four
);
    logic last_b;
    assign sensed_out = contact_in;
    always_ff @(posedge ref_clk_in)
    begin
        last_b <= contact_in[3];
        b_edges_out <= clr_in ? 8'h00 : b_edges_out + 8'(contact_in[3] & ~last_b);
    end
endmodule : mos_load

// ==== dv/multifunction_output_selector_test.sv ====
// Purpose: self-checking bench for the output selector
// Assumes: one wait state per bus access, outputs one edge after conditions
// Notes: short pulse length so the stretched codes finish quickly
`timescale 1ns/1ps
module multifunction_output_selector_test;
    import mos_pkg::*;
    localparam int unsigned PC = 20;
    logic clk = 0, srst = 1, rd = 0, wr = 0, clr = 1, wq, irq;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0000_0000, rdata;
    logic [3:0] be = 4'hF, con, sensed, rs;
    logic [7:0] bedg;
    logic [65:0] e;
    logic [65:0] expq [$];
    mos_cond_type cond = '0;
    mos_meas_type meas = '0;
    int fails = 0, cmp_count = 0, k;
    mos_output_select #(.PULSE_CYCLES(PC)) dut (.ref_clk_in(clk), .srst_in(srst),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wq),
        .cond_in(cond), .meas_in(meas), .relay_one_out(con[0]), .relay_two_out(con[1]),
        .transistor_output_a_out(con[2]), .transistor_output_b_out(con[3]), .irq_out(irq));
    mos_load load (.ref_clk_in(clk), .clr_in(clr), .contact_in(con), .sensed_out(sensed),
        .b_edges_out(bedg));
    initial
    begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            fails++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        while (wq !== 1'b0)
            @(posedge clk);
        rd <= 0;
        wr <= 0;
    endtask : bus
    // note holds irq-check flag, irq value, mask and value
    task automatic rd_exp(input logic [5:0] a, input logic [31:0] v, input logic [31:0] m,
        input logic [1:0] ic);
        expq.push_back({ic, m, v});
        bus(0, a, 32'h0000_0000);
    endtask : rd_exp
    task automatic st(input logic [3:0] v, input logic [1:0] ic = 2'b00);
        rd_exp(ADDR_STATE, {28'h000_0000, v}, 32'h0000_000F, ic);
    endtask : st
    task automatic lvl(input logic [5:0] code, input logic [20:0] off, input logic [20:0] on);
        bus(1, ADDR_SEL, {26'h000_0000, code});
        @(posedge clk) cond <= off;
        st(4'h0);
        @(posedge clk) cond <= on;
        st(4'h1);
        @(posedge clk) cond <= '0;
    endtask : lvl
    // ge: closes at equality; otherwise strictly above
    task automatic mth(input logic [5:0] code, input logic [5:0] a, input int sh, input logic ge);
        logic [15:0] t;
        t = 16'($urandom_range(100, 60000));
        bus(1, ADDR_SEL, {26'h000_0000, code});
        bus(1, a, {16'h0000, t});
        @(posedge clk) meas <= 80'(t - 16'(ge)) << sh;
        st(4'h0);
        @(posedge clk) meas <= 80'(t + 16'(!ge)) << sh;
        st(4'h1);
        @(posedge clk) meas <= '0;
    endtask : mth
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    // read data are taken at the edge at which waitrequest is sampled low
    always @(posedge clk)
    begin
        if (rd && wq === 1'b0)
        begin
            e = expq.pop_front();
            chk(rdata & e[63:32], e[31:0]);
            if (e[65])
                chk({31'h0, irq}, {31'h0, e[64]});
            if (e[63:32] == 32'h0000_000F)
                chk({28'h000_0000, sensed}, e[31:0]);
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
    initial
    begin
        void'($urandom(32'h4a1a));
        repeat (8) @(posedge clk);
        srst <= 0;
        clr <= 0;
        rd_exp(ADDR_SEL, 32'h0905_010B, 32'hFFFF_FFFF, 2'b10);
        rd_exp(ADDR_TARGET, 32'h0000_FFFF, 32'hFFFF_FFFF, 2'b00);
        rd_exp(ADDR_GAIN, 32'h0000_0100, 32'hFFFF_FFFF, 2'b00);
        rd_exp(6'h2C, 32'h0000_0000, 32'hFFFF_FFFF, 2'b00);
        rd_exp(6'h01, 32'h0000_0000, 32'hFFFF_FFFF, 2'b00);
        be <= 4'h0;
        bus(1, ADDR_POL, 32'h0000_000F);
        be <= 4'hF;
        rd_exp(ADDR_POL, 32'h0000_0000, 32'hFFFF_FFFF, 2'b00);
        bus(1, ADDR_POL, 32'h0000_000F);
        st(4'hF);
        @(posedge clk) cond <= 21'h10_0000;
        st(4'hE);
        @(posedge clk) cond <= '0;
        // second reset in mid-run must open every contact
        @(posedge clk) srst <= 1;
        repeat (2) @(posedge clk);
        chk({28'h000_0000, sensed}, 32'h0000_0000);
        srst <= 0;
        st(4'h0);
        lvl(SEL_FAULT, 21'h00_0000, 21'h10_0000);
        lvl(SEL_BLOCK, 21'h00_0000, 21'h08_0000);
        lvl(SEL_ZERO_RUN, 21'h06_0000, 21'h02_0000);
        lvl(SEL_ZERO_RUN, 21'h00_0000, 21'h02_0000);
        lvl(SEL_ZERO_ANY, 21'h04_0000, 21'h00_0000);
        lvl(SEL_SEQ_RUN, 21'h00_0000, 21'h01_0000);
        lvl(SEL_SEQ_PAUSE, 21'h00_0000, 21'h00_8000);
        lvl(SEL_BACKLASH, 21'h00_0000, 21'h00_1000);
        lvl(SEL_EXT_SRC, 21'h00_0000, 21'h00_0800);
        for (k = 0; k < 3; k++)
            lvl(SEL_AUX_BASE + 6'(k), 21'h00_0000, 21'h00_0100 << k);
        for (k = 0; k < 3; k++)
        begin
            rs = 4'($urandom);
            lvl(SEL_SEQ_STEP_BASE + 6'(rs), 21'h01_0000 | 21'(rs ^ 4'h1) << 4,
                21'h01_0000 | 21'(rs) << 4);
            lvl(SEL_SPEED_STEP_BASE + 6'(rs), 21'(rs ^ 4'h1), 21'(rs));
        end
        // fault rose earlier but mask is clear, so the line stays low
        rd_exp(ADDR_IRQ_STATUS, 32'h0000_0001, 32'hFFFF_FFFF, 2'b10);
        bus(1, ADDR_IRQ_STATUS, 32'h0000_000F);
        mth(SEL_TARGET, ADDR_TARGET, 64, 1);
        mth(SEL_PREWARN, ADDR_PREWARN, 64, 1);
        mth(SEL_OVERHEAT, ADDR_OVERHEAT, 48, 0);
        mth(SEL_OVERTORQUE, ADDR_TORQUE, 32, 0);
        bus(1, ADDR_IRQ_STATUS, 32'h0000_000F);
        bus(1, ADDR_IRQ_MASK, 32'h0000_0006);
        for (k = 0; k < 2; k++)
        begin
            bus(1, ADDR_SEL, {26'h000_0000, SEL_STEP_DONE + 6'(k)});
            @(posedge clk) cond <= 21'h00_4000 >> k;
            @(posedge clk) cond <= '0;
            st(4'h1, 2'b11);
            repeat (PC - 6) @(posedge clk);
            st(4'h1);
            repeat (6) @(posedge clk);
            st(4'h0, 2'b11);
            rd_exp(ADDR_IRQ_STATUS, 32'h0000_0002 << k, 32'hFFFF_FFFF, 2'b11);
            bus(1, ADDR_IRQ_STATUS, 32'h0000_0002 << k);
            rd_exp(ADDR_IRQ_STATUS, 32'h0000_0000, 32'hFFFF_FFFF, 2'b10);
        end
        bus(1, ADDR_SEL, 32'h001A_001A);
        bus(1, ADDR_BRAKE, 32'h0000_0100);
        @(posedge clk) meas.dc_bus <= 16'h0101;
        st(4'h4);
        bus(1, ADDR_SEL, 32'h1900_0019);
        @(posedge clk) meas.out_freq <= 16'h8000;
        clr <= 1;
        @(posedge clk) clr <= 0;
        repeat (20) @(posedge clk);
        chk({31'h0, bedg > 8'h02}, 32'h0000_0001);
        rd_exp(ADDR_STATE, 32'h0000_0000, 32'h0000_0001, 2'b00);
        conclude();
    end
endmodule : multifunction_output_selector_test
